// ---- cbs_defs.svh ----
// Offsets, field positions, reset values and widths for the card-side status bank.
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH
`define CBS_OFF_STATUS 8'h16
`define CBS_OFF_PRI_BUS 8'h18
`define CBS_OFF_CARD_BUS 8'h19
`define CBS_OFF_SUB_BUS 8'h1A
`define CBS_OFF_BRIDGE_CTL 8'h3E
`define CBS_BIT_PARITY 15
`define CBS_BIT_SERR 14
`define CBS_BIT_MABORT 13
`define CBS_BIT_TA_RECV 12
`define CBS_BIT_TA_SIG 11
`define CBS_BIT_DPAR 8
`define CBS_BIT_PERR_EN 0
`define CBS_SELECT_TIMING 2'h1
`define CBS_STATUS_RESET 16'h0200
`define CBS_BUS_RESET 8'h00
`define CBS_FUNCS 2
`define CBS_EVENTS 6
`endif

// ---- cbs_pkg.sv ----
// Types shared by the card-side status bank.
package cbs_pkg;
   typedef enum logic [1:0] {
      CBS_FWD_NONE,
      CBS_FWD_LOCAL,
      CBS_FWD_ONWARD
   } cbs_fwd_t;
endpackage

// ---- cbs_func_regs.sv ----
// One socket function's status flags and bus number registers.
`timescale 1ns/1ps
`include "cbs_defs.svh"
module cbs_func_regs
   import cbs_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Register write port.
   input wire logic i_wr,
   input wire logic [7:0] i_addr,
   input wire logic [3:0] i_be,
   input wire logic [31:0] i_wdata,
   // Event inputs, in flag order parity, serr, mabort, ta_recv, ta_sig, dpar.
   input wire logic [5:0] i_event,
   // Register contents.
   output logic [15:0] o_status,
   output logic [7:0] o_pri_bus,
   output logic [7:0] o_card_bus,
   output logic [7:0] o_sub_bus,
   output logic o_perr_en
);
   logic [5:0] flags;
   logic [5:0] clr;

   // Write-one clear of each flag, taken from the upper half of the 14h dword.
   always_comb begin
      clr = '0;
      if (i_wr && i_addr == 8'h14 && i_be[3]) begin
         clr[5:1] = i_wdata[31:27];
      end
      if (i_wr && i_addr == 8'h14 && i_be[3]) begin
         clr[0] = i_wdata[24];
      end
   end

   // Set beats clear so no event in a clear cycle is lost.
   genvar g;
   generate
      for (g = 0; g < `CBS_EVENTS; g++) begin : g_flag
         always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
               flags[g] <= 1'b0;
            end else if (i_event[g]) begin
               flags[g] <= 1'b1;
            end else if (clr[g]) begin
               flags[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Status word: fixed timing code, everything else but the flags is zero.
   assign o_status = {flags[5:1], `CBS_SELECT_TIMING, flags[0], 8'h00};

   // Bus numbers sit in bytes 0..2 of the 18h dword; parity response in 3Eh bit 0.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_pri_bus <= `CBS_BUS_RESET;
         o_card_bus <= `CBS_BUS_RESET;
         o_sub_bus <= `CBS_BUS_RESET;
         o_perr_en <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == 8'h18) begin
            if (i_be[0]) o_pri_bus <= i_wdata[7:0];
            if (i_be[1]) o_card_bus <= i_wdata[15:8];
            if (i_be[2]) o_sub_bus <= i_wdata[23:16];
         end else if (i_addr == 8'h3C && i_be[2]) begin
            o_perr_en <= i_wdata[16];
         end
      end
   end
endmodule

// ---- cbs_status_bank.sv ----
// Card-side error status and bus number configuration registers, two socket functions.
//***************************************************************
// Operation
// - Bit 15 sets on any card-side address or data parity error.
// - Bit 14 sets when a card asserts its system error line.
// - The bridge never drives the card system error line.
// - Bit 13 sets when our card-side cycle ends in master abort.
// - Bit 12 sets when our card-side cycle ends in target abort.
// - Bit 11 sets when we as target end with target abort.
// - Bits 10..9 read 01b, medium select timing; writes ignored.
// - Bit 8 sets on parity error while master with parity response enabled.
// - Bit 7 reads zero, no back-to-back acceptance.
// - Bit 6 reads zero, no user-definable features.
// - Bit 5 reads zero, card clock at most 33 MHz.
// - Bits 4..0 read zero.
// - Writing one to a flag clears it.
// - Each socket function has its own status register.
// - Forwarding uses card and subordinate bus numbers.
// - Each function has its own card bus number register.
// - Primary bus number is read/write, eight bits, resets to zero.
// - Each function has a writable subordinate number resetting to zero.
//***************************************************************
`timescale 1ns/1ps
`include "cbs_defs.svh"
module cbs_status_bank
   import cbs_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   // Configuration access: dword address, byte enables, one-cycle strobes.
   input wire logic i_cfg_func,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [31:0] i_cfg_wdata,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   // Card-side events per function, one-cycle pulses.
   input wire logic [1:0] i_parity_err,
   input wire logic [1:0] i_card_serr,
   input wire logic [1:0] i_mabort_recv,
   input wire logic [1:0] i_tabort_recv,
   input wire logic [1:0] i_tabort_sig,
   input wire logic [1:0] i_card_perr,
   input wire logic [1:0] i_bus_master,
   // Type 1 config cycle seen on the primary side, bus number to route.
   input wire logic i_fwd_req,
   input wire logic i_fwd_func,
   input wire logic [7:0] i_fwd_bus,
   output cbs_fwd_t o_fwd_kind,
   output logic o_fwd_valid,
   // Card system error drive, kept off permanently.
   output logic o_card_serr_oe
);
   logic [15:0] status [`CBS_FUNCS];
   logic [7:0] pri_bus [`CBS_FUNCS];
   logic [7:0] card_bus [`CBS_FUNCS];
   logic [7:0] sub_bus [`CBS_FUNCS];
   logic [1:0] perr_en;

   // Routing of a bus number against one function's window.
   function automatic cbs_fwd_t route(input logic [7:0] bus, input logic [7:0] cb,
                                      input logic [7:0] sb);
      if (bus == cb) begin
         route = CBS_FWD_LOCAL;
      end else if (bus > cb && bus <= sb) begin
         route = CBS_FWD_ONWARD;
      end else begin
         route = CBS_FWD_NONE;
      end
   endfunction

   //***************************************************************
   // Per-function register copies
   //***************************************************************
   // Separate instances keep each socket's flags private to it.
   genvar f;
   generate
      for (f = 0; f < `CBS_FUNCS; f++) begin : g_func
         logic [5:0] ev;
         // The data parity flag needs master ownership and the enable bit.
         assign ev = {i_parity_err[f], i_card_serr[f], i_mabort_recv[f], i_tabort_recv[f],
                      i_tabort_sig[f],
                      i_card_perr[f] & i_bus_master[f] & perr_en[f]};
         cbs_func_regs u_regs (
            .i_clk_sys(i_clk_sys),
            .i_sys_rst(i_sys_rst),
            .i_wr(i_cfg_wr && i_cfg_func == f[0]),
            .i_addr(i_cfg_addr),
            .i_be(i_cfg_be),
            .i_wdata(i_cfg_wdata),
            .i_event(ev),
            .o_status(status[f]),
            .o_pri_bus(pri_bus[f]),
            .o_card_bus(card_bus[f]),
            .o_sub_bus(sub_bus[f]),
            .o_perr_en(perr_en[f])
         );
      end
   endgenerate

   //***************************************************************
   // Read path
   //***************************************************************
   // Unmapped dwords read zero; the answer follows the strobe by one cycle.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_cfg_rdata <= 32'h0000_0000;
         o_cfg_rvalid <= 1'b0;
      end else begin
         o_cfg_rvalid <= i_cfg_rd;
         if (i_cfg_rd) begin
            if (i_cfg_addr == 8'h14) begin
               o_cfg_rdata <= {status[i_cfg_func], 16'h0000};
            end else if (i_cfg_addr == 8'h18) begin
               o_cfg_rdata <= {8'h00, sub_bus[i_cfg_func], card_bus[i_cfg_func],
                               pri_bus[i_cfg_func]};
            end else if (i_cfg_addr == 8'h3C) begin
               o_cfg_rdata <= {15'h0000, perr_en[i_cfg_func], 16'h0000};
            end else begin
               o_cfg_rdata <= 32'h0000_0000;
            end
         end
      end
   end

   //***************************************************************
   // Configuration forwarding
   //***************************************************************
   // A registered decision; the bridge engine samples it with the valid.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_fwd_kind <= CBS_FWD_NONE;
         o_fwd_valid <= 1'b0;
      end else begin
         o_fwd_valid <= i_fwd_req;
         if (i_fwd_req) begin
            o_fwd_kind <= route(i_fwd_bus, card_bus[i_fwd_func], sub_bus[i_fwd_func]);
         end
      end
   end

   // The bridge only observes the card system error line.
   always_ff @(posedge i_clk_sys) begin
      o_card_serr_oe <= 1'b0;
   end

   //***************************************************************
   // Checks
   //***************************************************************
   chk_serr_never: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      !o_card_serr_oe)
      else $error("card system error driven");
   chk_parity_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_parity_err[0] |=> status[0][15])
      else $error("parity flag missed");
   chk_serr_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_card_serr[1] |=> status[1][14])
      else $error("system error flag missed");
   chk_mabort_set: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      i_mabort_recv[0] |=> status[0][13])
      else $error("master abort flag missed");
   chk_tabort_both: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_tabort_recv[0] && i_tabort_sig[0]) |=> (status[0][12] && status[0][11]))
      else $error("target abort flags missed");
   chk_dpar_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (!status[0][8] && !(i_card_perr[0] && i_bus_master[0] && perr_en[0]))
      |=> !status[0][8])
      else $error("data parity flag set without cause");
   chk_fixed_bits: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      status[0][10:0] == {2'b01, status[0][8], 8'h00})
      else $error("fixed status bits wrong");
   chk_clear_one: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_cfg_wr && !i_cfg_func && i_cfg_addr == 8'h14 && i_cfg_be[3] && i_cfg_wdata[31]
       && !i_parity_err[0]) |=> !status[0][15])
      else $error("write one did not clear");
   chk_zero_keeps: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (status[0][14] && !(i_cfg_wr && !i_cfg_func && i_cfg_wdata[30])) |=> status[0][14])
      else $error("flag lost without write one");
   chk_private_flags: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (!status[1][13] && !i_mabort_recv[1] && !(i_cfg_wr && i_cfg_func)) |=> !status[1][13])
      else $error("function flags shared");
   chk_local_route: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_fwd_req && !i_fwd_func && i_fwd_bus == card_bus[0])
      |=> (o_fwd_valid && o_fwd_kind == CBS_FWD_LOCAL))
      else $error("local route wrong");
   chk_bus_reset: assert property (@(posedge i_clk_sys)
      $past(i_sys_rst) |-> (pri_bus[0] == 8'h00 && sub_bus[1] == 8'h00))
      else $error("bus numbers not reset");
   chk_card_bus_wr: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_cfg_wr && i_cfg_func && i_cfg_addr == 8'h18 && i_cfg_be[1])
      |=> card_bus[1] == $past(i_cfg_wdata[15:8]))
      else $error("card bus number not written");

   cov_local: cover property (@(posedge i_clk_sys) o_fwd_valid && o_fwd_kind == CBS_FWD_LOCAL);
   cov_onward: cover property (@(posedge i_clk_sys) o_fwd_valid && o_fwd_kind == CBS_FWD_ONWARD);
   cov_dpar: cover property (@(posedge i_clk_sys) status[1][8]);
   cov_set_clear: cover property (@(posedge i_clk_sys) i_parity_err[0] && i_cfg_wr
      && i_cfg_addr == 8'h14 && i_cfg_wdata[31]);
endmodule

// ---- cbs_card_model.sv ----
// Behavioural model of the card side, raising per-function bus event pulses.
`timescale 1ns/1ps
module cbs_card_model (
   // Clock.
   input wire logic i_clk_sys,
   // Event pulses towards the bridge, one bit per socket function.
   output logic [1:0] o_parity_err,
   output logic [1:0] o_card_serr,
   output logic [1:0] o_mabort_recv,
   output logic [1:0] o_tabort_recv,
   output logic [1:0] o_tabort_sig,
   output logic [1:0] o_card_perr,
   output logic [1:0] o_bus_master
);
   logic [1:0][6:0] ev = '0;
   // Mask bits: parity, system error, master abort, target abort in and out, perr, master.
   assign o_parity_err = {ev[1][0], ev[0][0]};
   assign o_card_serr = {ev[1][1], ev[0][1]};
   assign o_mabort_recv = {ev[1][2], ev[0][2]};
   assign o_tabort_recv = {ev[1][3], ev[0][3]};
   assign o_tabort_sig = {ev[1][4], ev[0][4]};
   assign o_card_perr = {ev[1][5], ev[0][5]};
   assign o_bus_master = {ev[1][6], ev[0][6]};
   // One-cycle pulse; dropped again so a stuck line cannot hide a missed clear.
   task automatic fire(input logic f, input logic [6:0] m);
      @(posedge i_clk_sys);
      #1 ev[f] = m;
      @(posedge i_clk_sys);
      #1 ev[f] = 7'h00;
   endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the card-side status and bus number bank.
`timescale 1ns/1ps
module tb_top;
   import cbs_pkg::*;
   localparam int MAX_CYCLES = 2000;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_cfg_func = 1'b0;
   logic [7:0] i_cfg_addr = 8'h00;
   logic [3:0] i_cfg_be = 4'h0;
   logic i_cfg_wr = 1'b0;
   logic i_cfg_rd = 1'b0;
   logic [31:0] i_cfg_wdata = 32'h0;
   logic [31:0] o_cfg_rdata;
   logic o_cfg_rvalid;
   logic [1:0] pe, se, ma, tr, ts, cp, bm;
   logic i_fwd_req = 1'b0;
   logic i_fwd_func = 1'b0;
   logic [7:0] i_fwd_bus = 8'h00;
   cbs_fwd_t o_fwd_kind;
   logic o_fwd_valid;
   logic o_card_serr_oe;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   cbs_card_model i_card (.i_clk_sys(i_clk_sys), .o_parity_err(pe), .o_card_serr(se),
      .o_mabort_recv(ma), .o_tabort_recv(tr), .o_tabort_sig(ts), .o_card_perr(cp),
      .o_bus_master(bm));
   cbs_status_bank i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_cfg_func(i_cfg_func), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
      .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_wdata(i_cfg_wdata),
      .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .i_parity_err(pe),
      .i_card_serr(se), .i_mabort_recv(ma), .i_tabort_recv(tr), .i_tabort_sig(ts),
      .i_card_perr(cp), .i_bus_master(bm), .i_fwd_req(i_fwd_req), .i_fwd_func(i_fwd_func),
      .i_fwd_bus(i_fwd_bus), .o_fwd_kind(o_fwd_kind), .o_fwd_valid(o_fwd_valid),
      .o_card_serr_oe(o_card_serr_oe));
   // 40 MHz system clock.
   always #12.5 i_clk_sys = ~i_clk_sys;
   // A hung handshake would stall the run forever, so cap it by cycles.
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == MAX_CYCLES) begin
         mismatches++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One-cycle write strobe; takes effect at the edge that samples it.
   task automatic cfg_wr(input logic f, input logic [7:0] a, input logic [3:0] be,
                         input logic [31:0] d);
      @(posedge i_clk_sys);
      #1 {i_cfg_func, i_cfg_addr, i_cfg_be, i_cfg_wdata, i_cfg_wr} = {f, a, be, d, 1'b1};
      @(posedge i_clk_sys);
      #1 i_cfg_wr = 1'b0;
   endtask
   // Read strobe, then answer checked in the single cycle that it stands.
   task automatic rd_chk(input logic f, input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clk_sys);
      #1 {i_cfg_func, i_cfg_addr, i_cfg_be, i_cfg_rd} = {f, a, 4'hF, 1'b1};
      @(posedge i_clk_sys);
      #1 i_cfg_rd = 1'b0;
      check({31'h0, o_cfg_rvalid}, 32'h1);
      check(o_cfg_rdata, exp);
   endtask
   task automatic route(input logic f, input logic [7:0] b, input cbs_fwd_t exp);
      @(posedge i_clk_sys);
      #1 {i_fwd_func, i_fwd_bus, i_fwd_req} = {f, b, 1'b1};
      @(posedge i_clk_sys);
      #1 i_fwd_req = 1'b0;
      check({31'h0, o_fwd_valid}, 32'h1);
      check({30'h0, o_fwd_kind}, {30'h0, exp});
   endtask
   //***************************************************************
   // Scenarios
   //***************************************************************
   task automatic t_reset();
      rd_chk(1'b0, 8'h14, 32'h0200_0000);
      rd_chk(1'b1, 8'h18, 32'h0000_0000);
      rd_chk(1'b0, 8'hF0, 32'h0000_0000);
   endtask
   // Every event but data parity at once on function 0; function 1 must stay untouched.
   task automatic t_events();
      i_card.fire(1'b0, 7'h1F);
      rd_chk(1'b0, 8'h14, 32'hFA00_0000);
      rd_chk(1'b1, 8'h14, 32'h0200_0000);
      cfg_wr(1'b0, 8'h14, 4'hF, 32'h0000_0000);
      rd_chk(1'b0, 8'h14, 32'hFA00_0000);
      cfg_wr(1'b0, 8'h14, 4'hC, 32'h5000_0000);
      rd_chk(1'b0, 8'h14, 32'hAA00_0000);
      cfg_wr(1'b0, 8'h14, 4'hC, 32'hFFFF_0000);
      rd_chk(1'b0, 8'h14, 32'h0200_0000);
      check({31'h0, o_card_serr_oe}, 32'h0);
   endtask
   // Data parity flag needs perr, mastership and the response enable together.
   task automatic t_dpar();
      i_card.fire(1'b0, 7'h60);
      rd_chk(1'b0, 8'h14, 32'h0200_0000);
      cfg_wr(1'b0, 8'h3C, 4'h4, 32'h0001_0000);
      i_card.fire(1'b0, 7'h20);
      rd_chk(1'b0, 8'h14, 32'h0200_0000);
      i_card.fire(1'b0, 7'h60);
      rd_chk(1'b0, 8'h14, 32'h0300_0000);
      cfg_wr(1'b0, 8'h14, 4'h8, 32'h0100_0000);
      rd_chk(1'b0, 8'h14, 32'h0200_0000);
   endtask
   // A new event in the same cycle as its clear must survive.
   task automatic t_race();
      fork
         i_card.fire(1'b1, 7'h03);
         cfg_wr(1'b1, 8'h14, 4'h8, 32'h8000_0000);
      join
      rd_chk(1'b1, 8'h14, 32'hC200_0000);
   endtask
   task automatic t_route();
      cfg_wr(1'b0, 8'h18, 4'h7, 32'h0008_0605);
      rd_chk(1'b0, 8'h18, 32'h0008_0605);
      rd_chk(1'b1, 8'h18, 32'h0000_0000);
      route(1'b0, 8'h06, CBS_FWD_LOCAL);
      route(1'b0, 8'h07, CBS_FWD_ONWARD);
      route(1'b0, 8'h08, CBS_FWD_ONWARD);
      route(1'b0, 8'h09, CBS_FWD_NONE);
      route(1'b0, 8'h05, CBS_FWD_NONE);
      route(1'b1, 8'h06, CBS_FWD_NONE);
   endtask
   // Reset for two cycles, then run every scenario in turn.
   initial begin
      repeat (2) @(posedge i_clk_sys);
      #1 i_sys_rst = 1'b0;
      t_reset();
      t_events();
      t_dpar();
      t_race();
      t_route();
      end_of_test();
   end
endmodule
